// file: rtl/rhls_pkg.sv
// Constants and types shared by the read/write head link controller
package rhls_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARMED = 3'b001,
    ST_PREFETCH = 3'b010,
    ST_DIRECT = 3'b011,
    ST_FAULT = 3'b100,
    ST_BUSY = 3'b101
  } rhls_state_t;

  typedef enum logic [1:0] {
    CMD_ARM = 2'b00,
    CMD_RELEASE = 2'b01,
    CMD_REARM = 2'b10,
    CMD_FAULT = 2'b11
  } rhls_cmd_t;

  // Tag request word: write flag, address, data
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int REQ_W = 1 + ADDR_W + DATA_W;
  localparam int REQ_WR_BIT = REQ_W - 1;
  localparam int REQ_ADDR_LSB = DATA_W;
  localparam int FIFO_DEPTH = 4;
  localparam int RETRY_MAX = 3;

  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int BOOT_SHOW_MS = 3000;
  localparam int BLINK_MS = 250;
  localparam int BOOT_CYCLES = CLK_HZ / 1000 * BOOT_SHOW_MS;
  localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;

  // Display characters (ASCII)
  localparam logic [7:0] CH_BLANK = 8'h20;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_BUS = 8'h50;
  localparam logic [7:0] CH_READY = 8'h2D;
  localparam logic [7:0] CH_NOBUS = 8'h5F;
  localparam logic [23:0] TXT_OFF = 24'h6F_6666;
  localparam logic [23:0] TXT_WAI = 24'h77_6169;
  localparam logic [23:0] TXT_PRE = 24'h70_7265;
  localparam logic [23:0] TXT_CON = 24'h63_6F6E;
  localparam logic [23:0] TXT_ERR = 24'h45_3030;
  localparam logic [23:0] TXT_BSY = 24'h62_7379;
endpackage

// file: rtl/rhls_disp_if.sv
// Carrier between the link controller and the status display driver
`timescale 1ns/100ps
interface rhls_disp_if;
  import rhls_pkg::*;
  rhls_state_t state;
  logic [7:0] node_addr;
  logic bus_ok;
  logic [31:0] chars;
  modport ctl(output state, output node_addr, output bus_ok, input chars);
  modport disp(input state, input node_addr, input bus_ok, output chars);
endinterface

// file: rtl/rhls_fifo.sv
// Buffer for the prefetch transfer list
`timescale 1ns/100ps
module rhls_fifo #(
  parameter int WIDTH = rhls_pkg::REQ_W,
  parameter int DEPTH = rhls_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_r;
  logic [PW-1:0] rd_r;
  logic [PW:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = cnt_r != (PW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rd_r];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= push ? PW'((wr_r + 1'b1) % DEPTH) : wr_r;
      rd_r <= pop ? PW'((rd_r + 1'b1) % DEPTH) : rd_r;
      cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  a_fifo_no_over: assert property (@(posedge clock) disable iff (!rst_n)
    cnt_r <= (PW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule

// file: rtl/rhls_display.sv
// Four-character status display driver
`timescale 1ns/100ps
module rhls_display #(
  parameter int BOOT_CYC = rhls_pkg::BOOT_CYCLES,
  parameter int BLINK_CYC = rhls_pkg::BLINK_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Status from the controller
  rhls_disp_if.disp dif
);
  import rhls_pkg::*;
  logic [25:0] boot_r;
  logic [25:0] blink_r;
  logic flash_r;
  logic [31:0] chars_r;
  logic [23:0] area1;
  wire booting = boot_r != 26'(BOOT_CYC);
  wire [7:0] d100 = CH_ZERO + 8'(dif.node_addr / 100);
  wire [7:0] d10 = CH_ZERO + 8'((dif.node_addr / 10) % 10);
  wire [7:0] d1 = CH_ZERO + 8'(dif.node_addr % 10);
  wire [7:0] area2 = dif.bus_ok ? CH_READY : CH_NOBUS;

  always_comb begin
    case (dif.state)
      ST_IDLE: area1 = TXT_OFF;
      ST_ARMED: area1 = TXT_WAI;
      ST_PREFETCH: area1 = TXT_PRE;
      ST_DIRECT: area1 = TXT_CON;
      ST_FAULT: area1 = flash_r ? {3{CH_BLANK}} : TXT_ERR;
      default: area1 = TXT_BSY;
    endcase
  end

  assign dif.chars = chars_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      boot_r <= '0;
      blink_r <= '0;
      flash_r <= 1'b0;
      chars_r <= {4{CH_BLANK}};
    end else begin
      boot_r <= booting ? boot_r + 1'b1 : boot_r;
      blink_r <= (blink_r == 26'(BLINK_CYC - 1)) ? '0 : blink_r + 1'b1;
      flash_r <= (blink_r == 26'(BLINK_CYC - 1)) ? !flash_r : flash_r;
      chars_r <= booting ? {CH_BUS, d100, d10, d1} : {area1, area2};
    end
  end

  a_fault_shows_code: assert property (@(posedge clock) disable iff (!rst_n)
    !booting && dif.state == ST_FAULT && !flash_r |=> chars_r[31:8] == TXT_ERR)
    else $error("fault code not shown");
endmodule

// file: rtl/rhls_head.sv
// Link-state controller of the read/write head
`timescale 1ns/100ps
// Overview of operation
// - After reset the head is idle, field off, commands accepted.
// - Idle goes to armed only by command; armed switches the field on.
// - Arm legal in idle or fault; release legal in direct or armed.
// - Re-arm legal in direct; force-fault legal in idle, armed or direct.
// - Tag sign-on in armed moves to prefetch by itself.
// - Prefetch runs all buffered transfers, then ends by itself.
// - Prefetch end: auto re-arm to armed, auto release to idle, else direct.
// - Tag leaving during prefetch gives fault.
// - Direct state runs host read/write requests at once, returns data.
// - Tag leaving during direct state gives fault.
// - Direct exchange failure is reported to host; state stays direct.
// - Sign-on failure in armed gives fault.
// - Sign-off failure on any exit from prefetch or direct gives fault.
// - Repeated failed tag attempts in prefetch give fault; fault flashes its code.
// - While a host command or an auto prefetch exit is handled the state reads busy.
// - Current link state is always readable by the host.
// - Cover lamp on when tag transfer starts, off when host ends it.
// - Display: three state or error characters, one readiness character.
// - At power-up the node address is shown for a few seconds.
module rhls_head #(
  parameter int BOOT_CYC = rhls_pkg::BOOT_CYCLES,
  parameter int BLINK_CYC = rhls_pkg::BLINK_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Host link-state commands and status
  input wire logic cmd_valid,
  input wire rhls_pkg::rhls_cmd_t cmd_code,
  output rhls_pkg::rhls_state_t link_state,
  input wire logic auto_rearm,
  input wire logic auto_release,
  // Host buffered transfer load
  input wire logic prm_valid,
  output logic prm_ready,
  input wire logic [rhls_pkg::REQ_W-1:0] prm_data,
  // Host direct requests and answers
  input wire logic dir_valid,
  output logic dir_ready,
  input wire logic [rhls_pkg::REQ_W-1:0] dir_data,
  output logic host_rsp_valid,
  output logic host_rsp_err,
  output logic [rhls_pkg::DATA_W-1:0] host_rsp_data,
  // Tag presence and sign-on/off
  input wire logic tag_present,
  input wire logic tag_signon,
  input wire logic tag_signon_fail,
  output logic tag_signoff_req,
  input wire logic tag_signoff_done,
  input wire logic tag_signoff_fail,
  // Tag transfer channel
  output logic tag_req_valid,
  input wire logic tag_req_ready,
  output logic [rhls_pkg::REQ_W-1:0] tag_req_data,
  input wire logic tag_rsp_valid,
  input wire logic tag_rsp_err,
  input wire logic [rhls_pkg::DATA_W-1:0] tag_rsp_data,
  // Field, lamp and display
  output logic powering_field,
  output logic cover_lamp,
  input wire logic [7:0] node_addr,
  input wire logic bus_ok,
  output logic [31:0] disp_chars
);
  import rhls_pkg::*;

  logic rst_q1;
  logic rst_n;
  rhls_state_t state_r;
  rhls_state_t state_nxt;
  rhls_state_t target_r;
  rhls_state_t target_nxt;
  logic soff_r;
  logic soff_nxt;
  logic lamp_r;
  logic req_valid_r;
  logic outst_r;
  logic [REQ_W-1:0] req_r;
  logic [1:0] fail_r;
  logic rsp_valid_r;
  logic rsp_err_r;
  logic [DATA_W-1:0] rsp_data_r;
  logic fifo_valid;
  logic fifo_in_ready;
  logic [REQ_W-1:0] fifo_data;

  // Reset release through two flops
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // Command legality
  wire in_idle = state_r == ST_IDLE;
  wire in_armed = state_r == ST_ARMED;
  wire in_pre = state_r == ST_PREFETCH;
  wire in_dir = state_r == ST_DIRECT;
  wire in_fault = state_r == ST_FAULT;
  wire in_busy = state_r == ST_BUSY;
  wire ok_arm = cmd_code == CMD_ARM && (in_idle || in_fault);
  wire ok_rel = cmd_code == CMD_RELEASE && (in_dir || in_armed);
  wire ok_rearm = cmd_code == CMD_REARM && in_dir;
  wire ok_flt = cmd_code == CMD_FAULT && (in_idle || in_armed || in_dir);
  wire cmd_ok = cmd_valid && (ok_arm || ok_rel || ok_rearm || ok_flt);
  wire rhls_state_t cmd_target = (ok_arm || ok_rearm) ? ST_ARMED :
                                 ok_rel ? ST_IDLE : ST_FAULT;

  // Transfer engine status
  wire tag_gone = (in_pre || in_dir) && !tag_present;
  wire engine_idle = !req_valid_r && !outst_r;
  wire pre_done = in_pre && !fifo_valid && engine_idle;
  wire pre_pop = in_pre && engine_idle;
  wire fifo_pop = pre_pop && fifo_valid;
  wire dir_take = dir_valid && dir_ready;
  wire rsp_fail = tag_rsp_valid && tag_rsp_err;
  wire retry_out = in_pre && rsp_fail && fail_r == 2'(RETRY_MAX - 1);
  wire retry = in_pre && rsp_fail && !retry_out;
  wire soff_bad = tag_signoff_fail || !tag_present;

  // Link state sequencing; tag events take priority over host commands
  always_comb begin
    state_nxt = state_r;
    target_nxt = target_r;
    soff_nxt = soff_r;
    case (state_r)
      ST_ARMED: begin
        if (tag_signon_fail) begin
          state_nxt = ST_FAULT;
        end else if (tag_signon) begin
          state_nxt = ST_PREFETCH;
        end else if (cmd_ok) begin
          state_nxt = ST_BUSY;
          target_nxt = cmd_target;
          soff_nxt = 1'b0;
        end
      end
      ST_PREFETCH: begin
        if (tag_gone || retry_out) begin
          state_nxt = ST_FAULT;
        end else if (pre_done && (auto_rearm || auto_release)) begin
          state_nxt = ST_BUSY;
          target_nxt = auto_rearm ? ST_ARMED : ST_IDLE;
          soff_nxt = 1'b1;
        end else if (pre_done) begin
          state_nxt = ST_DIRECT;
        end
      end
      ST_DIRECT: begin
        if (tag_gone) begin
          state_nxt = ST_FAULT;
        end else if (cmd_ok) begin
          state_nxt = ST_BUSY;
          target_nxt = cmd_target;
          soff_nxt = 1'b1;
        end
      end
      ST_BUSY: begin
        if (!soff_r) begin
          state_nxt = target_r;
        end else if (soff_bad) begin
          state_nxt = ST_FAULT;
          soff_nxt = 1'b0;
        end else if (tag_signoff_done) begin
          state_nxt = target_r;
          soff_nxt = 1'b0;
        end
      end
      default: begin
        if (cmd_ok) begin
          state_nxt = ST_BUSY;
          target_nxt = cmd_target;
          soff_nxt = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      target_r <= ST_IDLE;
      soff_r <= 1'b0;
      lamp_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      target_r <= target_nxt;
      soff_r <= soff_nxt;
      // Lamp holds through the sign-off so it drops only when the exit completes, host or auto
      lamp_r <= state_nxt == ST_PREFETCH || state_nxt == ST_DIRECT ||
                (lamp_r && state_nxt == ST_BUSY);
    end
  end

  // Tag request channel; a failed prefetch word is reissued from the held copy
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      req_valid_r <= 1'b0;
      outst_r <= 1'b0;
      req_r <= '0;
      fail_r <= '0;
    end else if (!(in_pre || in_dir)) begin
      req_valid_r <= 1'b0;
      outst_r <= 1'b0;
      fail_r <= '0;
    end else begin
      req_valid_r <= fifo_pop || dir_take || retry || (req_valid_r && !tag_req_ready);
      outst_r <= (outst_r && !tag_rsp_valid) || (req_valid_r && tag_req_ready);
      req_r <= fifo_pop ? fifo_data : dir_take ? dir_data : req_r;
      fail_r <= retry ? fail_r + 1'b1 : (tag_rsp_valid ? '0 : fail_r);
    end
  end

  // Answers to the host, errors included
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_r <= 1'b0;
      rsp_err_r <= 1'b0;
      rsp_data_r <= '0;
    end else begin
      rsp_valid_r <= tag_rsp_valid && (in_dir || (in_pre && !retry));
      rsp_err_r <= tag_rsp_valid && tag_rsp_err;
      rsp_data_r <= tag_rsp_valid ? tag_rsp_data : rsp_data_r;
    end
  end

  // Loading is blocked while a tag sits in the live field
  wire load_ok = !powering_field || !tag_present;

  rhls_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(prm_valid && load_ok),
    .in_ready(fifo_in_ready),
    .in_data(prm_data),
    .out_valid(fifo_valid),
    .out_ready(pre_pop),
    .out_data(fifo_data)
  );

  rhls_disp_if dif ();
  assign dif.state = state_r;
  assign dif.node_addr = node_addr;
  assign dif.bus_ok = bus_ok;

  rhls_display #(.BOOT_CYC(BOOT_CYC), .BLINK_CYC(BLINK_CYC)) u_disp (
    .clock(clock),
    .rst_n(rst_n),
    .dif(dif)
  );

  assign prm_ready = fifo_in_ready && load_ok;
  assign dir_ready = in_dir && tag_present && engine_idle && !cmd_valid;
  assign link_state = state_r;
  assign powering_field = in_armed || in_pre || in_dir || (in_busy && soff_r);
  assign cover_lamp = lamp_r;
  assign tag_signoff_req = in_busy && soff_r;
  assign tag_req_valid = req_valid_r;
  assign tag_req_data = req_r;
  assign host_rsp_valid = rsp_valid_r;
  assign host_rsp_err = rsp_err_r;
  assign host_rsp_data = rsp_data_r;
  assign disp_chars = dif.chars;

  // Checks
  a_idle_field_off: assert property (@(posedge clock) disable iff (!rst_n)
    in_idle |-> !powering_field)
    else $error("field on in idle");
  a_arm_to_armed: assert property (@(posedge clock) disable iff (!rst_n)
    in_idle && cmd_valid && cmd_code == CMD_ARM |=> in_busy ##1 in_armed && powering_field)
    else $error("arm from idle failed");
  a_release_signoff: assert property (@(posedge clock) disable iff (!rst_n)
    in_dir && tag_present && cmd_valid && cmd_code == CMD_RELEASE
    |=> in_busy && tag_signoff_req && target_r == ST_IDLE)
    else $error("release did not start sign-off");
  a_rearm_illegal: assert property (@(posedge clock) disable iff (!rst_n)
    in_idle && cmd_valid && cmd_code == CMD_REARM |=> in_idle)
    else $error("illegal re-arm acted");
  a_fault_from_armed: assert property (@(posedge clock) disable iff (!rst_n)
    in_armed && !tag_signon && !tag_signon_fail && cmd_valid && cmd_code == CMD_FAULT
    |=> in_busy ##1 in_fault)
    else $error("force fault failed");
  a_signon_prefetch: assert property (@(posedge clock) disable iff (!rst_n)
    in_armed && tag_signon && !tag_signon_fail |=> in_pre ##0 cover_lamp)
    else $error("sign-on did not start prefetch");
  a_signon_fail: assert property (@(posedge clock) disable iff (!rst_n)
    in_armed && tag_signon_fail |=> in_fault)
    else $error("sign-on failure not faulted");
  a_prefetch_plain: assert property (@(posedge clock) disable iff (!rst_n)
    pre_done && tag_present && !auto_rearm && !auto_release |=> in_dir)
    else $error("prefetch end not direct");
  a_prefetch_auto: assert property (@(posedge clock) disable iff (!rst_n)
    pre_done && tag_present && auto_rearm |=> in_busy && soff_r && target_r == ST_ARMED)
    else $error("auto re-arm exit wrong");
  a_tag_gone_fault: assert property (@(posedge clock) disable iff (!rst_n)
    tag_gone |=> in_fault)
    else $error("early tag exit not faulted");
  a_direct_err_stays: assert property (@(posedge clock) disable iff (!rst_n)
    in_dir && tag_present && !cmd_valid && rsp_fail |=> in_dir && host_rsp_valid && host_rsp_err)
    else $error("direct error not reported");
  a_signoff_fail: assert property (@(posedge clock) disable iff (!rst_n)
    in_busy && soff_r && tag_signoff_fail |=> in_fault ##1 !cover_lamp)
    else $error("sign-off failure not faulted");
  a_retry_fault: assert property (@(posedge clock) disable iff (!rst_n)
    retry_out && tag_present |=> in_fault)
    else $error("retries did not fault");
  a_load_blocked: assert property (@(posedge clock) disable iff (!rst_n)
    powering_field && tag_present |-> !prm_ready)
    else $error("load allowed with tag in field");

  c_prefetch_direct: cover property (@(posedge clock) disable iff (!rst_n)
    in_pre ##1 in_dir);
  c_auto_rearm: cover property (@(posedge clock) disable iff (!rst_n)
    in_busy && soff_r ##1 in_armed);
  c_tag_leaves: cover property (@(posedge clock) disable iff (!rst_n)
    in_dir ##1 in_fault);
  c_direct_error: cover property (@(posedge clock) disable iff (!rst_n)
    host_rsp_valid && host_rsp_err);
endmodule

// file: test/rhls_tag_model.sv
// Behavioural model of the mobile tag behind the powering field
`timescale 1ns/100ps
module rhls_tag_model (
  // Clock
  input wire logic clock,
  // Bench controls
  input wire logic [3:0] delay,
  input wire logic errs_on,
  input wire logic soff_fail,
  // Transfer channel
  input wire logic tag_req_valid,
  output logic tag_req_ready,
  input wire logic [rhls_pkg::REQ_W-1:0] tag_req_data,
  output logic tag_rsp_valid,
  output logic tag_rsp_err,
  output logic [rhls_pkg::DATA_W-1:0] tag_rsp_data,
  // Sign-off
  input wire logic tag_signoff_req,
  output logic tag_signoff_done,
  output logic tag_signoff_fail
);
  import rhls_pkg::*;
  logic [7:0] mem [16];
  logic [3:0] wcnt = 4'h0;
  logic pend = 0, sent = 0;
  logic [REQ_W-1:0] req = '0;
  initial begin
    tag_rsp_valid = 0;
    tag_rsp_err = 0;
    tag_rsp_data = 8'h00;
    tag_signoff_done = 0;
    tag_signoff_fail = 0;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // Slow answers stretch the wait for ready by delay cycles
  assign tag_req_ready = tag_req_valid && !pend && !tag_rsp_valid && wcnt >= delay;
  always @(posedge clock) begin
    tag_rsp_valid <= 0;
    // Idle answer lines keep moving so stale data never looks valid
    tag_rsp_err <= ~tag_rsp_err;
    tag_rsp_data <= ~tag_rsp_data;
    tag_signoff_done <= 0;
    tag_signoff_fail <= 0;
    if (tag_req_valid && !tag_req_ready && wcnt != 4'hF) wcnt <= wcnt + 4'h1;
    else wcnt <= 4'h0;
    if (tag_req_valid && tag_req_ready) begin
      pend <= 1;
      req <= tag_req_data;
    end
    if (pend) begin
      pend <= 0;
      tag_rsp_valid <= 1;
      tag_rsp_err <= errs_on;
      tag_rsp_data <= mem[req[REQ_ADDR_LSB +: 4]];
      if (req[REQ_WR_BIT] && !errs_on) mem[req[REQ_ADDR_LSB +: 4]] <= req[7:0];
    end
    if (!tag_signoff_req) sent <= 0;
    else if (!sent) begin
      sent <= 1;
      tag_signoff_done <= !soff_fail;
      tag_signoff_fail <= soff_fail;
    end
  end
endmodule

// file: test/tb_rhls_head.sv
// Bench for the read/write head link controller
`timescale 1ns/100ps
module tb_rhls_head;
  import rhls_pkg::*;
  logic clock = 0, resetn = 0, cmd_valid = 0, auto_rearm = 0, auto_release = 0;
  rhls_cmd_t cmd_code = CMD_ARM;
  rhls_state_t link_state;
  logic prm_valid = 0, dir_valid = 0, tag_present = 0, tag_signon = 0, tag_signon_fail = 0;
  logic [REQ_W-1:0] prm_data = '0, dir_data = '0, tag_req_data;
  logic prm_ready, dir_ready, host_rsp_valid, host_rsp_err, tag_signoff_req;
  logic tag_signoff_done, tag_signoff_fail, tag_req_valid, tag_req_ready, tag_rsp_valid;
  logic tag_rsp_err, powering_field, cover_lamp, bus_ok = 1, errs_on = 0, soff_fail = 0;
  logic [7:0] host_rsp_data, tag_rsp_data, node_addr = 8'h7B;
  logic [3:0] delay = 4'h2;
  logic [31:0] disp_chars;
  logic se, sb;
  int err_count = 0, compares = 0, takes = 0, cyc = 0, t0;
  always #25 clock = ~clock;
  // Short boot and blink counts keep the run brief
  rhls_head #(.BOOT_CYC(20), .BLINK_CYC(4)) uut (.*);
  rhls_tag_model tag (.*);
  task automatic finish_test;
    $display("Mismatches %0d, comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_st(input rhls_state_t e);
    compares++;
    if (link_state !== e) begin
      err_count++;
      $display("FAIL %0t state %0d, expected %0d", $time, link_state, e);
    end
  endtask
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %0t value %h, expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %0t flag %b, expected %b", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wait_st(input rhls_state_t e);
    int n;
    n = 0;
    while (link_state !== e && n < 300) begin
      tick(1);
      n++;
    end
    chk_st(e);
  endtask
  task automatic send_cmd(input rhls_cmd_t c, input logic ok);
    @(posedge clock);
    cmd_valid <= 1;
    cmd_code <= c;
    @(posedge clock);
    cmd_valid <= 0;
    #1;
    if (ok) chk_st(ST_BUSY);
  endtask
  task automatic load(input logic [REQ_W-1:0] w);
    int n;
    @(posedge clock);
    prm_valid <= 1;
    prm_data <= w;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (prm_ready !== 1 && n < 50);
    chk_bit(prm_ready, 1);
    prm_valid <= 0;
  endtask
  task automatic direct(input logic [REQ_W-1:0] w, input logic [7:0] d, input logic e);
    int n;
    @(posedge clock);
    dir_valid <= 1;
    dir_data <= w;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (dir_ready !== 1 && n < 50);
    chk_bit(dir_ready, 1);
    dir_valid <= 0;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (host_rsp_valid !== 1 && n < 50);
    chk_bit(host_rsp_valid, 1);
    chk_bit(host_rsp_err, e);
    if (!e) chk_val({24'h00_0000, host_rsp_data}, {24'h00_0000, d});
  endtask
  task automatic sign(input logic f);
    @(posedge clock);
    if (f) tag_signon_fail <= 1;
    else tag_signon <= 1;
    @(posedge clock);
    tag_signon <= 0;
    tag_signon_fail <= 0;
    #1;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (tag_req_valid && tag_req_ready) takes++;
    if (cyc == 20000) begin
      err_count++;
      $display("FAIL %0t timeout", $time);
      finish_test;
    end
  end
  initial begin
    tick(4);
    @(posedge clock) resetn <= 1;
    tick(6);
    chk_st(ST_IDLE);
    chk_bit(powering_field, 0);
    chk_val(disp_chars, 32'h5031_3233);
    tick(25);
    chk_val(disp_chars, {TXT_OFF, CH_READY});
    @(posedge clock) bus_ok <= 0;
    tick(3);
    chk_val(disp_chars, {TXT_OFF, CH_NOBUS});
    @(posedge clock) bus_ok <= 1;
    send_cmd(CMD_RELEASE, 0);
    send_cmd(CMD_REARM, 0);
    tick(2);
    chk_st(ST_IDLE);
    load({1'b1, 16'h0001, 8'h5A});
    load({1'b1, 16'h0002, 8'hA5});
    load({1'b0, 16'h0001, 8'h00});
    load({1'b0, 16'h0002, 8'h00});
    #1;
    chk_bit(prm_ready, 0);
    send_cmd(CMD_ARM, 1);
    wait_st(ST_ARMED);
    chk_bit(powering_field, 1);
    @(posedge clock) tag_present <= 1;
    sign(0);
    chk_st(ST_PREFETCH);
    chk_bit(cover_lamp, 1);
    wait_st(ST_DIRECT);
    chk_val(takes, 4);
    direct({1'b0, 16'h0001, 8'h00}, 8'h5A, 0);
    direct({1'b0, 16'h0002, 8'h00}, 8'hA5, 0);
    @(posedge clock) errs_on <= 1;
    direct({1'b1, 16'h0003, 8'h33}, 8'h00, 1);
    @(posedge clock) errs_on <= 0;
    chk_st(ST_DIRECT);
    send_cmd(CMD_REARM, 1);
    wait_st(ST_ARMED);
    chk_bit(cover_lamp, 0);
    sign(0);
    wait_st(ST_DIRECT);
    @(posedge clock) tag_present <= 0;
    wait_st(ST_FAULT);
    se = 0;
    sb = 0;
    repeat (12) begin
      tick(1);
      if (disp_chars[31:8] === TXT_ERR) se = 1;
      if (disp_chars[31:8] === 24'h20_2020) sb = 1;
    end
    chk_bit(se & sb, 1);
    send_cmd(CMD_ARM, 1);
    wait_st(ST_ARMED);
    send_cmd(CMD_FAULT, 1);
    wait_st(ST_FAULT);
    send_cmd(CMD_ARM, 1);
    wait_st(ST_ARMED);
    @(posedge clock) tag_present <= 1;
    sign(1);
    wait_st(ST_FAULT);
    send_cmd(CMD_ARM, 1);
    @(posedge clock) tag_present <= 0;
    wait_st(ST_ARMED);
    load({1'b1, 16'h0004, 8'h44});
    @(posedge clock) delay <= 4'hF;
    tag_present <= 1;
    sign(0);
    @(posedge clock) tag_present <= 0;
    wait_st(ST_FAULT);
    @(posedge clock) resetn <= 0;
    tick(2);
    @(posedge clock) resetn <= 1;
    delay <= 4'h2;
    tick(4);
    chk_st(ST_IDLE);
    chk_bit(powering_field, 0);
    send_cmd(CMD_ARM, 1);
    wait_st(ST_ARMED);
    load({1'b1, 16'h0005, 8'h55});
    t0 = takes;
    @(posedge clock) errs_on <= 1;
    tag_present <= 1;
    sign(0);
    wait_st(ST_FAULT);
    chk_val(takes - t0, RETRY_MAX);
    @(posedge clock) errs_on <= 0;
    tag_present <= 0;
    // Auto release first, then auto re-arm, both from a fresh arm
    for (int i = 0; i < 2; i++) begin
      @(posedge clock) auto_release <= (i == 0);
      auto_rearm <= (i == 1);
      send_cmd(CMD_ARM, 1);
      wait_st(ST_ARMED);
      @(posedge clock) tag_present <= 1;
      sign(0);
      wait_st(i == 0 ? ST_IDLE : ST_ARMED);
      if (i == 0) @(posedge clock) tag_present <= 0;
    end
    @(posedge clock) auto_rearm <= 0;
    sign(0);
    wait_st(ST_DIRECT);
    @(posedge clock) soff_fail <= 1;
    send_cmd(CMD_RELEASE, 1);
    wait_st(ST_FAULT);
    @(posedge clock) soff_fail <= 0;
    tag_present <= 0;
    send_cmd(CMD_REARM, 0);
    tick(2);
    chk_st(ST_FAULT);
    send_cmd(CMD_ARM, 1);
    wait_st(ST_ARMED);
    send_cmd(CMD_RELEASE, 1);
    wait_st(ST_IDLE);
    finish_test;
  end
endmodule
